/* hw/scp_pkg.sv */
// Shared constants and carriers for the serial controller register pointer.
// Assumes a single 125 MHz host-side clock and synchronous active-high reset.
package scp_pkg;
   localparam int SCP_DW = 8;
   localparam logic [7:0] SCP_CMD_RESET = 8'h00;
   localparam logic [7:0] SCP_EXT_RESET = 8'h00;
   localparam logic [7:0] SCP_AUX_RESET = 8'h00;
   localparam int SCP_PTR_LSB = 0;
   localparam int SCP_PTR_MSB = 2;
   localparam int SCP_POINT_LSB = 3;
   localparam int SCP_POINT_MSB = 5;
   localparam logic [2:0] SCP_POINT_HIGH = 3'h1;
   localparam int SCP_CRC_LSB = 6;
   localparam int SCP_CRC_MSB = 7;
   localparam int SCP_FIFO_EN_BIT = 2;
   localparam int SCP_EXT_RD_BIT = 6;
   localparam logic [3:0] SCP_REG_CMD = 4'h0;
   localparam logic [3:0] SCP_REG_VECTOR = 4'h2;
   localparam logic [3:0] SCP_REG_WR3 = 4'h3;
   localparam logic [3:0] SCP_REG_WR4 = 4'h4;
   localparam logic [3:0] SCP_REG_WR5 = 4'h5;
   localparam logic [3:0] SCP_REG_WR7 = 4'h7;
   localparam logic [3:0] SCP_REG_MASTER = 4'h9;
   localparam logic [3:0] SCP_REG_WR10 = 4'hA;
   localparam logic [3:0] SCP_REG_EXT_STATUS_CTRL_REG = 4'hF;

   typedef enum logic [1:0] {
      SCP_CRC_NULL = 2'b00,
      SCP_CRC_RX_RESET = 2'b01,
      SCP_CRC_TX_RESET = 2'b10,
      SCP_CRC_EOM_RESET = 2'b11
   } scp_crc_cmd_t;

   // Where a read is served from
   typedef enum logic [1:0] {
      SCP_SRC_RR = 2'b00,
      SCP_SRC_WR = 2'b01
   } scp_src_t;

   typedef struct packed {
      scp_src_t src;
      logic [3:0] idx;
   } scp_rd_sel_t;

   typedef struct packed {
      logic rxCrcReset;
      logic txCrcReset;
      logic eomReset;
   } scp_crc_pulse_t;
endpackage : scp_pkg

/* hw/scp_read_map.sv */
// Read-location remap for one channel.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module scp_read_map
   import scp_pkg::*;
(
   input wire logic [3:0] loc,
   input wire logic fifoEn,
   input wire logic extRd,
   output scp_rd_sel_t sel
);
   always_comb begin
      sel.src = SCP_SRC_RR;
      sel.idx = loc;
      case (loc)
         4'h4: begin
            if (extRd) begin
               sel.src = SCP_SRC_WR;
               sel.idx = SCP_REG_WR4;
            end else begin
               sel.idx = 4'h0;
            end
         end
         4'h5: begin
            if (extRd) begin
               sel.src = SCP_SRC_WR;
               sel.idx = SCP_REG_WR5;
            end else begin
               sel.idx = 4'h1;
            end
         end
         4'h6: sel.idx = fifoEn ? 4'h6 : 4'h2;
         4'h7: sel.idx = fifoEn ? 4'h7 : 4'h3;
         4'h9: begin
            if (extRd) begin
               sel.src = SCP_SRC_WR;
               sel.idx = SCP_REG_WR3;
            end else begin
               sel.idx = 4'hD;
            end
         end
         4'hB: begin
            if (extRd) begin
               sel.src = SCP_SRC_WR;
               sel.idx = SCP_REG_WR10;
            end else begin
               sel.idx = 4'hF;
            end
         end
         4'hE: begin
            if (extRd) begin
               sel.src = SCP_SRC_WR;
               sel.idx = SCP_REG_WR7;
            end
         end
         default: begin
            sel.src = SCP_SRC_RR;
            sel.idx = loc;
         end
      endcase
   end
endmodule : scp_read_map

/* hw/scp_register_pointer.sv */
// Register pointer, command decode and read remap for a two-channel serial controller.
// Assumes the host issues one access per cycle on hostWr/hostRd strobes on core_clk,
// and that the rest of the device holds the register contents this block indexes.
// How it works
// - Command bits 2:0 point at registers 0-7
// - Point-high command moves pointer to 8-15
// - Status FIFO bit swaps locations 6,7
// - Extended read returns written values at 4,5,9,11,14
// - Unbacked locations alias read registers 0,1,13,15
// - Bits 7:6 decode CRC and underrun resets
`timescale 1ns/1ps
module scp_register_pointer
   import scp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic hostWr,
   input wire logic hostRd,
   input wire logic chanB,
   input wire logic [7:0] hostWdata,
   output logic [3:0] regIdx,
   output logic regChanB,
   output logic regShared,
   output logic regWrite,
   output logic [7:0] regWdata,
   output logic regRead,
   output logic rdFromWr,
   output logic [3:0] rdIdx,
   output logic rdChanB,
   output logic rxCrcResetA,
   output logic txCrcResetA,
   output logic eomResetA,
   output logic rxCrcResetB,
   output logic txCrcResetB,
   output logic eomResetB,
   output logic [3:0] pointerA,
   output logic [3:0] pointerB,
   output logic fifoEnA,
   output logic fifoEnB,
   output logic extRdA,
   output logic extRdB
);
   typedef struct packed {
      logic [3:0] ptrA;
      logic [3:0] ptrB;
      logic [7:0] extCtrlA;
      logic [7:0] extCtrlB;
      logic [7:0] auxA;
      logic [7:0] auxB;
      logic [3:0] regIdx;
      logic regChanB;
      logic regShared;
      logic regWrite;
      logic [7:0] regWdata;
      logic regRead;
      logic rdFromWr;
      logic [3:0] rdIdx;
      logic rdChanB;
      scp_crc_pulse_t crcA;
      scp_crc_pulse_t crcB;
      logic extRdA;
      logic extRdB;
   } scp_state_t;

   scp_state_t st_q;
   scp_state_t st_d;
   logic [3:0] curPtr;
   logic curFifo;
   logic curExt;
   scp_rd_sel_t rdSel;

   function automatic scp_crc_pulse_t crc_decode(input logic [1:0] code);
      scp_crc_pulse_t p;
      p = '0;
      case (scp_crc_cmd_t'(code))
         SCP_CRC_RX_RESET: p.rxCrcReset = 1'b1;
         SCP_CRC_TX_RESET: p.txCrcReset = 1'b1;
         SCP_CRC_EOM_RESET: p.eomReset = 1'b1;
         default: p = '0;
      endcase
      return p;
   endfunction : crc_decode

   function automatic logic is_shared(input logic [3:0] idx);
      return (idx == SCP_REG_VECTOR) || (idx == SCP_REG_MASTER);
   endfunction : is_shared

   // Pointer field plus the point-high command give the full register number
   function automatic logic [3:0] ptr_decode(input logic [7:0] data);
      logic high;
      high = (data[SCP_POINT_MSB:SCP_POINT_LSB] == SCP_POINT_HIGH);
      return {high, data[SCP_PTR_MSB:SCP_PTR_LSB]};
   endfunction : ptr_decode

   assign curPtr = chanB ? st_q.ptrB : st_q.ptrA;
   // Aux register bit 6 only takes effect while the status FIFO bit is also set
   assign curFifo = chanB ? st_q.extCtrlB[SCP_FIFO_EN_BIT] : st_q.extCtrlA[SCP_FIFO_EN_BIT];
   assign curExt = curFifo && (chanB ? st_q.auxB[SCP_EXT_RD_BIT] : st_q.auxA[SCP_EXT_RD_BIT]);

   scp_read_map u_map (
      .loc(curPtr),
      .fifoEn(curFifo),
      .extRd(curExt),
      .sel(rdSel)
   );

   always_comb begin
      st_d = st_q;
      st_d.regWrite = 1'b0;
      st_d.regRead = 1'b0;
      st_d.crcA = '0;
      st_d.crcB = '0;
      if (hostWr) begin
         st_d.regWrite = 1'b1;
         st_d.regIdx = curPtr;
         st_d.regChanB = chanB;
         st_d.regShared = is_shared(curPtr);
         st_d.regWdata = hostWdata;
         if (curPtr == SCP_REG_CMD) begin
            // A pointer write arms the next access only; command then points back at 0
            if (chanB) begin
               st_d.ptrB = ptr_decode(hostWdata);
               st_d.crcB = crc_decode(hostWdata[SCP_CRC_MSB:SCP_CRC_LSB]);
            end else begin
               st_d.ptrA = ptr_decode(hostWdata);
               st_d.crcA = crc_decode(hostWdata[SCP_CRC_MSB:SCP_CRC_LSB]);
            end
         end else begin
            if (chanB) begin
               st_d.ptrB = SCP_REG_CMD;
            end else begin
               st_d.ptrA = SCP_REG_CMD;
            end
            if (curPtr == SCP_REG_EXT_STATUS_CTRL_REG) begin
               if (chanB) begin
                  st_d.extCtrlB = hostWdata;
               end else begin
                  st_d.extCtrlA = hostWdata;
               end
            end
            // Register 7 becomes the aux register while the FIFO bit is set
            if (curPtr == SCP_REG_WR7 && curFifo) begin
               if (chanB) begin
                  st_d.auxB = hostWdata;
               end else begin
                  st_d.auxA = hostWdata;
               end
            end
         end
      // A read in the same cycle as a write is dropped; the write wins
      end else if (hostRd) begin
         st_d.regRead = 1'b1;
         st_d.rdFromWr = (rdSel.src == SCP_SRC_WR);
         st_d.rdIdx = rdSel.idx;
         st_d.rdChanB = chanB;
         if (chanB) begin
            st_d.ptrB = SCP_REG_CMD;
         end else begin
            st_d.ptrA = SCP_REG_CMD;
         end
      end
      // Held in a flop so the output carries no decode; follows a write to either bit
      st_d.extRdA = st_d.extCtrlA[SCP_FIFO_EN_BIT] & st_d.auxA[SCP_EXT_RD_BIT];
      st_d.extRdB = st_d.extCtrlB[SCP_FIFO_EN_BIT] & st_d.auxB[SCP_EXT_RD_BIT];
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.extCtrlA <= SCP_EXT_RESET;
         st_q.extCtrlB <= SCP_EXT_RESET;
         st_q.auxA <= SCP_AUX_RESET;
         st_q.auxB <= SCP_AUX_RESET;
         st_q.regWdata <= SCP_CMD_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign regIdx = st_q.regIdx;
   assign regChanB = st_q.regChanB;
   assign regShared = st_q.regShared;
   assign regWrite = st_q.regWrite;
   assign regWdata = st_q.regWdata;
   assign regRead = st_q.regRead;
   assign rdFromWr = st_q.rdFromWr;
   assign rdIdx = st_q.rdIdx;
   assign rdChanB = st_q.rdChanB;
   assign rxCrcResetA = st_q.crcA.rxCrcReset;
   assign txCrcResetA = st_q.crcA.txCrcReset;
   assign eomResetA = st_q.crcA.eomReset;
   assign rxCrcResetB = st_q.crcB.rxCrcReset;
   assign txCrcResetB = st_q.crcB.txCrcReset;
   assign eomResetB = st_q.crcB.eomReset;
   assign pointerA = st_q.ptrA;
   assign pointerB = st_q.ptrB;
   assign fifoEnA = st_q.extCtrlA[SCP_FIFO_EN_BIT];
   assign fifoEnB = st_q.extCtrlB[SCP_FIFO_EN_BIT];
   assign extRdA = st_q.extRdA;
   assign extRdB = st_q.extRdB;
endmodule : scp_register_pointer

/* tb/scp_host.sv */
// Host processor model on the parallel register port.
// Assumes each task is entered just after a falling clock edge.
`timescale 1ns/1ps
module scp_host
   import scp_pkg::*;
(
   input wire logic clk,
   output logic hostWr,
   output logic hostRd,
   output logic chanB,
   output logic [7:0] hostWdata
);
   initial begin
      hostWr = 1'b0;
      hostRd = 1'b0;
      chanB = 1'b0;
      hostWdata = 8'h00;
   end
   task automatic acc(input logic w, input logic ch, input logic [7:0] d);
      hostWr = w;
      hostRd = !w;
      chanB = ch;
      hostWdata = d;
      @(negedge clk);
      hostWr = 1'b0;
      hostRd = 1'b0;
      // Released bus must not look like the last value
      hostWdata = ~d;
      @(negedge clk);
   endtask : acc
   task automatic point(input logic ch, input logic [3:0] r);
      acc(1'b1, ch, {2'b00, r[3] ? SCP_POINT_HIGH : 3'h0, r[2:0]});
   endtask : point
endmodule : scp_host

/* tb/scp_register_pointer_chk.sv */
// Port-level checks for the register pointer block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module scp_register_pointer_chk
   import scp_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic hostWr,
   input wire logic hostRd,
   input wire logic chanB,
   input wire logic [7:0] hostWdata,
   input wire logic [3:0] regIdx,
   input wire logic regShared,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic rdChanB,
   input wire logic rxCrcResetA,
   input wire logic txCrcResetA,
   input wire logic eomResetA,
   input wire logic rxCrcResetB,
   input wire logic txCrcResetB,
   input wire logic eomResetB,
   input wire logic [3:0] pointerA,
   input wire logic [3:0] pointerB,
   input wire logic fifoEnA,
   input wire logic extRdA
);
   logic cmdWrA;
   logic cmdWrB;
   logic ptHigh;
   // A write taken while the channel points at 0 is a command write
   assign cmdWrA = hostWr && !chanB && pointerA == 4'h0;
   assign cmdWrB = hostWr && chanB && pointerB == 4'h0;
   assign ptHigh = hostWdata[5:3] == SCP_POINT_HIGH;
   function automatic logic [2:0] crc_exp(input logic [1:0] code);
      return {code == 2'b01, code == 2'b10, code == 2'b11};
   endfunction : crc_exp
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_write_pulse_seen: assert property (regWrite == $past(hostWr)) else $error("write pulse wrong");
   a_read_pulse_seen: assert property (hostRd && !hostWr |=> regRead) else $error("read pulse missing");
   a_pointer_low_set: assert property (cmdWrA && !ptHigh |=> pointerA == {1'b0, $past(hostWdata[2:0])})
      else $error("low pointer wrong");
   a_pointer_high_set: assert property (cmdWrA && ptHigh |=> pointerA == {1'b1, $past(hostWdata[2:0])})
      else $error("high pointer wrong");
   a_pointer_b_set: assert property (cmdWrB |=> pointerB == {$past(ptHigh), $past(hostWdata[2:0])})
      else $error("channel b pointer wrong");
   a_pointer_read_clear: assert property (hostRd && !hostWr && !chanB |=> pointerA == 4'h0)
      else $error("pointer kept after read");
   a_crc_decode_a: assert property (cmdWrA
      |=> {rxCrcResetA, txCrcResetA, eomResetA} == crc_exp($past(hostWdata[7:6]))) else $error("crc command a wrong");
   a_crc_decode_b: assert property (cmdWrB
      |=> {rxCrcResetB, txCrcResetB, eomResetB} == crc_exp($past(hostWdata[7:6]))) else $error("crc command b wrong");
   a_crc_quiet_a: assert property (!cmdWrA |=> !(rxCrcResetA || txCrcResetA || eomResetA))
      else $error("stray crc pulse a");
   a_crc_quiet_b: assert property (!cmdWrB |=> !(rxCrcResetB || txCrcResetB || eomResetB))
      else $error("stray crc pulse b");
   a_shared_flag: assert property (regWrite |-> regShared == (regIdx == SCP_REG_VECTOR || regIdx == SCP_REG_MASTER))
      else $error("shared flag wrong");
   a_ext_needs_fifo: assert property (extRdA |-> fifoEnA) else $error("ext read without fifo");
   a_read_chan_sel: assert property (hostRd && !hostWr |=> rdChanB == $past(chanB)) else $error("read chan wrong");
endmodule : scp_register_pointer_chk

bind scp_register_pointer scp_register_pointer_chk u_chk (.core_clk, .srst, .hostWr, .hostRd, .chanB, .hostWdata,
   .regIdx, .regShared, .regWrite, .regRead, .rdChanB, .rxCrcResetA, .txCrcResetA, .eomResetA, .rxCrcResetB,
   .txCrcResetB, .eomResetB, .pointerA, .pointerB, .fifoEnA, .extRdA);

/* tb/testbench.sv */
// Self-checking bench for the register pointer block.
// Assumes the host model issues one access every two cycles.
`timescale 1ns/1ps
module testbench
   import scp_pkg::*;
;
   logic core_clk = 1'b0;
   logic srst = 1'b1;
   logic hostWr, hostRd, chanB, regChanB, regShared, regWrite, regRead, rdFromWr, rdChanB;
   logic rxCrcResetA, txCrcResetA, eomResetA, rxCrcResetB, txCrcResetB, eomResetB;
   logic fifoEnA, fifoEnB, extRdA, extRdB, c, f, e;
   logic [7:0] hostWdata, regWdata, d;
   logic [3:0] regIdx, rdIdx, pointerA, pointerB, r;
   logic [2:0] crcSeenA, crcSeenB;
   logic fe [2];
   logic ax [2];
   int n_mismatch = 0;
   int samples_checked = 0;
   always #4 core_clk = ~core_clk;
   scp_host host (.clk(core_clk), .hostWr, .hostRd, .chanB, .hostWdata);
   scp_register_pointer dut (.core_clk, .srst, .hostWr, .hostRd, .chanB, .hostWdata, .regIdx, .regChanB,
      .regShared, .regWrite, .regWdata, .regRead, .rdFromWr, .rdIdx, .rdChanB, .rxCrcResetA, .txCrcResetA,
      .eomResetA, .rxCrcResetB, .txCrcResetB, .eomResetB, .pointerA, .pointerB, .fifoEnA, .fifoEnB, .extRdA,
      .extRdB);
   assign crcSeenA = {rxCrcResetA, txCrcResetA, eomResetA};
   assign crcSeenB = {rxCrcResetB, txCrcResetB, eomResetB};
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   function automatic logic [4:0] emap(input logic [3:0] l, input logic fo, input logic xo);
      if (fo && xo && l inside {4'h4, 4'h5, 4'h9, 4'hB, 4'hE}) begin
         return (l == 4'h9) ? 5'h13 : (l == 4'hB) ? 5'h1A : (l == 4'hE) ? 5'h17 : {1'b1, l};
      end
      case (l)
         4'h4: return 5'h00;
         4'h5: return 5'h01;
         4'h6: return fo ? 5'h06 : 5'h02;
         4'h7: return fo ? 5'h07 : 5'h03;
         4'h9: return 5'h0D;
         4'hB: return 5'h0F;
         default: return {1'b0, l};
      endcase
   endfunction : emap
   function automatic logic [2:0] crcexp(input logic [1:0] code);
      return {code == 2'b01, code == 2'b10, code == 2'b11};
   endfunction : crcexp
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      #100000;
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'h66bad0cd));
      fe = '{1'b0, 1'b0};
      ax = '{1'b0, 1'b0};
      repeat (12) @(negedge core_clk);
      srst = 1'b0;
      chk({pointerA, pointerB}, 8'h00);
      for (int k = 0; k < 64; k++) begin
         c = k[5];
         r = k[3:0];
         // Register 0 data keeps the pointer at 0
         d = (r == 4'h0) ? {k[4], k[5], 6'h00} : 8'($urandom);
         host.point(c, r);
         chk(c ? pointerB : pointerA, r);
         host.acc(1'b1, c, d);
         if (r == 4'hF) fe[c] = d[SCP_FIFO_EN_BIT];
         if (r == 4'h7 && fe[c]) ax[c] = d[SCP_EXT_RD_BIT];
         chk(regIdx, r);
         chk(regWdata, d);
         chk(regChanB, c);
         chk(regShared, r == 4'h2 || r == 4'h9);
         chk(c ? fifoEnB : fifoEnA, fe[c]);
         chk(c ? extRdB : extRdA, fe[c] & ax[c]);
      end
      $display("test pointer done");
      for (int k = 0; k < 6; k++) begin
         c = k[0];
         f = k < 4;
         e = k < 2;
         host.point(c, 4'hF);
         host.acc(1'b1, c, {5'h00, f, 2'b00});
         fe[c] = f;
         if (f) begin
            host.point(c, 4'h7);
            host.acc(1'b1, c, {1'b0, e, 6'h00});
            ax[c] = e;
         end
         for (int l = 0; l < 16; l++) begin
            host.point(c, l[3:0]);
            host.acc(1'b0, c, 8'($urandom));
            chk({rdFromWr, rdIdx}, emap(l[3:0], fe[c], ax[c]));
            chk(rdChanB, c);
         end
      end
      $display("test readmap done");
      // Every reset code on both channels; the pulse stands for the cycle after the write
      for (int k = 0; k < 8; k++) begin
         c = k[2];
         d = {k[1:0], 6'h00};
         fork
            host.acc(1'b1, c, d);
            begin
               @(negedge core_clk);
               chk(c ? crcSeenB : crcSeenA, crcexp(d[7:6]));
            end
         join
         chk(c ? crcSeenB : crcSeenA, 3'h0);
         chk(c ? pointerB : pointerA, 4'h0);
      end
      $display("test crc done");
      // Reset in mid-run must clear the status FIFO enable again
      host.point(1'b0, 4'hF);
      host.acc(1'b1, 1'b0, 8'h04);
      chk(fifoEnA, 1'b1);
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      chk({fifoEnA, extRdA, pointerA}, 6'h00);
      fe[0] = 1'b0;
      $display("test reset done");
      tally_and_finish;
   end
endmodule : testbench
